// ===== common/amp_irq_pkg.sv
// Functional notes
// R1: pin style 00 high, 01 low, 10 open-drain
// R2: overflow trigger bit, 0 level, 1 edge
// R3: edge mode: overflow status read clears channels
// R4: mask 1 lets source reach pin; reset zero
// R5: mask bits align; pin event uses pin mask
// R6: flag set if event since last read
// R7: status read clears the five event flags
// R8: status layout bits 7..1, bit 0 reserved
// R9: status read keeps overflow and pin flags
// R10: edge mode: source register read clears flag
// R11: level mode: active source survives source read
// R12: level flag cleared by read once inactive
// R13: unlock set by port error or lost lock
// R14: unlock flag set on entry transition only
// R15: lock event clears pending unlock flag
// R16: unlock event clears pending lock flag
// R17: ramp done flags set when ramps finish
// R18: overflow flag is OR of channel bits
// R19: pin flag is OR of unmasked pin bits
// R20: pin asserted while any unmasked flag set
// R21: open-drain pulls low when pending, else released
package amp_irq_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned N_CH_DEF = 6;
	localparam int unsigned N_PIN_DEF = 4;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_STYLE_CTRL = 6'h28;
	localparam logic [5:0] IDX_ENABLE_MASK = 6'h29;
	localparam logic [5:0] IDX_EVENT_FLAGS = 6'h2A;
	localparam logic [5:0] IDX_CLIP_STATUS = 6'h2B;
	localparam logic [5:0] IDX_PIN_TRIGGER = 6'h2E;
	localparam logic [5:0] IDX_PIN_STATUS = 6'h2F;
	localparam logic [5:0] IDX_PIN_MASK = 6'h30;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned STYLE_LSB = 6;
	localparam int unsigned OVF_TYPE_BIT = 0;
	localparam int unsigned EVT_LSB = 3;
	localparam int unsigned FLAG_OVF = 2;
	localparam int unsigned FLAG_PIN = 1;
	localparam logic [7:0] MASK_WRITABLE = 8'hFC;

	// ----------------------------------------
	// pin style codes
	// ----------------------------------------
	localparam logic [1:0] STYLE_ACTIVE_HIGH = 2'h0;
	localparam logic [1:0] STYLE_ACTIVE_LOW = 2'h1;
	localparam logic [1:0] STYLE_OPEN_DRAIN = 2'h2;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [1:0] RST_STYLE = 2'h0;
	localparam logic RST_OVF_TYPE = 1'b0;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic RST_PIN_BIT = 1'b0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic port_error;     // audio input port error level
		logic conv_locked;    // rate converter lock level
		logic ramp_up_done;   // one-cycle pulse, all ramps up finished
		logic ramp_down_done; // one-cycle pulse, all ramps down finished
		logic mute_done;      // one-cycle pulse, mute cycle finished
	} src_events_type;

	typedef struct packed {
		logic level;          // value driven when enabled
		logic oe_n;           // low while driving
	} irq_pin_type;

endpackage

// ===== rtl/amp_interrupt_aggregator.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module amp_interrupt_aggregator #(
	parameter int unsigned N_CH = amp_irq_pkg::N_CH_DEF,
	parameter int unsigned N_PIN = amp_irq_pkg::N_PIN_DEF
) (
	input wire logic clk_i,                          // 40 MHz clock
	input wire logic rst_i,                          // sync reset, high
	input wire logic wb_cyc_i,                       // bus cycle
	input wire logic wb_stb_i,                       // bus strobe
	input wire logic wb_we_i,                        // write enable
	input wire logic [7:0] wb_adr_i,                 // byte address
	input wire logic [3:0] wb_sel_i,                 // byte lanes
	input wire logic [31:0] wb_dat_i,                // write data
	output logic [31:0] wb_dat_o,                    // read data
	output logic wb_ack_o,                           // acknowledge
	input wire amp_irq_pkg::src_events_type src_i,   // converter and ramp events
	input wire logic [N_CH-1:0] channel_clip_bit_i,  // per channel clip
	input wire logic [N_PIN-1:0] pin_event_i,        // async pin inputs
	output amp_irq_pkg::irq_pin_type irq_pin_o       // interrupt pin drive
);
	import amp_irq_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [1:0] irq_pin_style;
		logic overflow_trigger_type;
		logic [7:0] enable_mask;
		logic [N_PIN-1:0] pin_trigger;
		logic [N_PIN-1:0] pin_mask;
		logic [N_PIN-1:0] pin_s1;
		logic [N_PIN-1:0] pin_s2;
		logic [N_PIN-1:0] pin_s3;
		logic [N_PIN-1:0] pin_filt;
		logic [N_PIN-1:0] pin_status;
		logic [N_CH-1:0] clip_prev;
		logic [N_CH-1:0] clip_status;
		logic unlock_prev;
		logic rate_conv_unlock_flag;
		logic rate_conv_lock_flag;
		logic ramp_up_done_flag;
		logic ramp_down_done_flag;
		logic mute_done_flag;
		logic irq_level;
		logic irq_oe_n;
	} state_type;

	state_type st_reg;
	state_type st_next;

	// ----------------------------------------
	// combinational helpers
	// ----------------------------------------
	logic req;
	logic [5:0] idx;
	logic wr_done;
	logic rd_done;
	logic [7:0] flags;
	logic overflow_flag;
	logic pin_flag;
	logic pending;
	logic unlock_cond;
	logic unlock_rise;
	logic lock_rise;
	logic evt_clr;
	logic [4:0] evt_clr_bits;
	logic [N_CH-1:0] clip_clr;
	logic [N_CH-1:0] clip_set;
	logic [N_PIN-1:0] pin_clr;
	logic [N_PIN-1:0] pin_set;
	logic [N_PIN-1:0] pin_rise;
	logic [N_PIN-1:0] pin_agree;
	logic [7:0] rd_mux;

	// bus request decode; the word index hides the byte offset
	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[7:2];

	// side effects only at the edge where the master sees ack
	assign wr_done = req & st_reg.ack & wb_we_i & wb_sel_i[0];
	assign rd_done = req & st_reg.ack & ~wb_we_i;

	// summary flags
	assign overflow_flag = |st_reg.clip_status; // R18
	assign pin_flag = |(st_reg.pin_status & st_reg.pin_mask); // R19

	// status byte layout
	always_comb begin
		flags = 8'h00;
		flags[7] = st_reg.rate_conv_unlock_flag; // R8
		flags[6] = st_reg.rate_conv_lock_flag;
		flags[5] = st_reg.ramp_up_done_flag;
		flags[4] = st_reg.ramp_down_done_flag;
		flags[3] = st_reg.mute_done_flag;
		flags[FLAG_OVF] = overflow_flag;
		flags[FLAG_PIN] = pin_flag;
	end

	// pin is masked by its own register, not the main mask
	assign pending = (|(flags[7:2] & st_reg.enable_mask[7:2])) | pin_flag; // R4 R5 R20

	// ----------------------------------------
	// rate converter transitions
	// ----------------------------------------
	// either an input port fault or lost lock counts as unlocked
	assign unlock_cond = src_i.port_error | ~src_i.conv_locked; // R13
	assign unlock_rise = unlock_cond & ~st_reg.unlock_prev; // R14
	assign lock_rise = ~unlock_cond & st_reg.unlock_prev;

	// ----------------------------------------
	// read-clear masks
	// ----------------------------------------
	// clear only what the master was shown, so an event that lands
	// between capture and ack survives to the next read
	assign evt_clr = rd_done & (idx == IDX_EVENT_FLAGS);
	assign evt_clr_bits = evt_clr ? st_reg.rdata[7:EVT_LSB] : 5'h00; // R7 R9
	assign clip_clr = (rd_done & (idx == IDX_CLIP_STATUS)) ?
		st_reg.rdata[N_CH-1:0] : {N_CH{1'b0}}; // R3 R10
	assign pin_clr = (rd_done & (idx == IDX_PIN_STATUS)) ?
		st_reg.rdata[N_PIN-1:0] : {N_PIN{1'b0}}; // R10

	// ----------------------------------------
	// set terms
	// ----------------------------------------
	// level mode re-sets while the source is active, so a read
	// cannot clear it; edge mode only sets on the rising edge
	assign clip_set = st_reg.overflow_trigger_type ?
		(channel_clip_bit_i & ~st_reg.clip_prev) : channel_clip_bit_i; // R2 R11 R12

	// a pin change counts once the second and third stages agree
	assign pin_agree = ~(st_reg.pin_s2 ^ st_reg.pin_s3);
	assign pin_rise = pin_agree & st_reg.pin_s2 & ~st_reg.pin_filt;
	assign pin_set = (st_reg.pin_trigger & pin_rise) |
		(~st_reg.pin_trigger & st_reg.pin_filt); // R11 R12

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			IDX_STYLE_CTRL: begin
				rd_mux[STYLE_LSB+1:STYLE_LSB] = st_reg.irq_pin_style;
				rd_mux[OVF_TYPE_BIT] = st_reg.overflow_trigger_type;
			end
			IDX_ENABLE_MASK: begin
				rd_mux = st_reg.enable_mask;
			end
			IDX_EVENT_FLAGS: begin
				rd_mux = flags;
			end
			IDX_CLIP_STATUS: begin
				rd_mux = 8'(st_reg.clip_status);
			end
			IDX_PIN_TRIGGER: begin
				rd_mux = 8'(st_reg.pin_trigger);
			end
			IDX_PIN_STATUS: begin
				rd_mux = 8'(st_reg.pin_status);
			end
			IDX_PIN_MASK: begin
				rd_mux = 8'(st_reg.pin_mask);
			end
			default: begin
				// unmapped words read as zero and still acknowledge
				rd_mux = 8'h00;
			end
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;

		// single-cycle ack, one cycle after the request is seen
		st_next.ack = req & ~st_reg.ack;
		if (req & ~st_reg.ack) begin
			st_next.rdata = rd_mux;
		end

		// configuration writes
		if (wr_done) begin
			case (idx)
				IDX_STYLE_CTRL: begin
					st_next.irq_pin_style = wb_dat_i[STYLE_LSB+1:STYLE_LSB]; // R1
					st_next.overflow_trigger_type = wb_dat_i[OVF_TYPE_BIT]; // R2
				end
				IDX_ENABLE_MASK: begin
					st_next.enable_mask = wb_dat_i[7:0] & MASK_WRITABLE; // R4 R5
				end
				IDX_PIN_TRIGGER: begin
					st_next.pin_trigger = wb_dat_i[N_PIN-1:0];
				end
				IDX_PIN_MASK: begin
					st_next.pin_mask = wb_dat_i[N_PIN-1:0]; // R5
				end
				default: begin
					st_next.rdata = st_next.rdata;
				end
			endcase
		end

		// pin synchroniser, first stage feeds only the second
		st_next.pin_s1 = pin_event_i;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2;
		st_next.pin_filt = (pin_agree & st_reg.pin_s2) | (~pin_agree & st_reg.pin_filt);

		// sticky pin and channel status, set wins over clear
		st_next.pin_status = pin_set | (st_reg.pin_status & ~pin_clr); // R6 R10
		st_next.clip_prev = channel_clip_bit_i;
		st_next.clip_status = clip_set | (st_reg.clip_status & ~clip_clr); // R6 R18

		// converter state: only the latest transition is kept
		st_next.unlock_prev = unlock_cond;
		st_next.rate_conv_unlock_flag = unlock_rise |
			(st_reg.rate_conv_unlock_flag & ~evt_clr_bits[4] & ~lock_rise); // R14 R15
		st_next.rate_conv_lock_flag = lock_rise |
			(st_reg.rate_conv_lock_flag & ~evt_clr_bits[3] & ~unlock_rise); // R16

		// ramp and mute completion events
		st_next.ramp_up_done_flag = src_i.ramp_up_done |
			(st_reg.ramp_up_done_flag & ~evt_clr_bits[2]); // R17
		st_next.ramp_down_done_flag = src_i.ramp_down_done |
			(st_reg.ramp_down_done_flag & ~evt_clr_bits[1]); // R17
		st_next.mute_done_flag = src_i.mute_done |
			(st_reg.mute_done_flag & ~evt_clr_bits[0]); // R6 R7

		// pin drive; reserved style leaves the pin released
		case (st_reg.irq_pin_style)
			STYLE_ACTIVE_HIGH: begin
				st_next.irq_level = pending; // R1 R20
				st_next.irq_oe_n = 1'b0;
			end
			STYLE_ACTIVE_LOW: begin
				st_next.irq_level = ~pending; // R1 R20
				st_next.irq_oe_n = 1'b0;
			end
			STYLE_OPEN_DRAIN: begin
				st_next.irq_level = 1'b0;
				st_next.irq_oe_n = ~pending; // R21
			end
			default: begin
				st_next.irq_level = 1'b0;
				st_next.irq_oe_n = 1'b1;
			end
		endcase

		// synchronous reset, constants only
		if (rst_i) begin
			st_next = '0;
			st_next.irq_pin_style = RST_STYLE; // R1
			st_next.overflow_trigger_type = RST_OVF_TYPE; // R2
			st_next.enable_mask = RST_MASK; // R4
			st_next.pin_trigger = {N_PIN{RST_PIN_BIT}};
			st_next.pin_mask = {N_PIN{RST_PIN_BIT}};
			st_next.pin_status = {N_PIN{RST_PIN_BIT}};
			st_next.clip_status = {N_CH{1'b0}}; // R3
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		st_reg <= st_next;
	end

	// outputs straight from flops
	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = {24'h000000, st_reg.rdata};
	assign irq_pin_o.level = st_reg.irq_level;
	assign irq_pin_o.oe_n = st_reg.irq_oe_n;

endmodule

// ===== testbench/amp_interrupt_aggregator_checker.sv
`timescale 1ns/1ps
module amp_irq_checker (
	input wire logic clk_i,                        // clock
	input wire logic rst_i,                        // reset
	input wire logic wb_cyc_i,                     // cycle
	input wire logic wb_stb_i,                     // strobe
	input wire logic wb_we_i,                      // write
	input wire logic [7:0] wb_adr_i,               // address
	input wire logic [3:0] wb_sel_i,               // lanes
	input wire logic [31:0] wb_dat_i,              // write data
	input wire logic [31:0] wb_dat_o,              // read data
	input wire logic wb_ack_o,                     // ack
	input wire amp_irq_pkg::src_events_type src_i, // events
	input wire amp_irq_pkg::irq_pin_type irq_pin_o // pin
);
	import amp_irq_pkg::*;
	logic [1:0] style_q;
	logic [7:0] mask_q;
	logic wr_ok;
	// mirror style and mask, so pin checks know what software chose
	assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			style_q <= 2'h0;
			mask_q <= 8'h00;
		end else if (wr_ok && wb_adr_i == 8'hA0) begin
			style_q <= wb_dat_i[7:6];
		end else if (wr_ok && wb_adr_i == 8'hA4) begin
			mask_q <= wb_dat_i[7:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd_s(logic [7:0] a);
		req_s ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	ack_resp_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
	ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)
		&& wb_dat_o[31:8] == 24'h0) else $error("stray ack");
	rsvd_flag_a: assert property (rd_s(8'hA8) |=> !wb_dat_o[0])
		else $error("reserved flag set");
	mask_rd_a: assert property (rd_s(8'hA4) |=> wb_dat_o[7:0] == (mask_q & 8'hFC))
		else $error("mask readback");
	style_rd_a: assert property (rd_s(8'hA0) |=> wb_dat_o[7:6] == style_q)
		else $error("style readback");
	od_low_a: assert property (style_q == STYLE_OPEN_DRAIN && $stable(style_q)
		|-> !irq_pin_o.level) else $error("open drain drove high");
	pp_drive_a: assert property (!style_q[1] && $stable(style_q) |-> !irq_pin_o.oe_n)
		else $error("push-pull released");
	evt_pin_a: assert property (style_q == 2'h0 && mask_q[EVT_LSB] && src_i.mute_done
		|-> ##2 irq_pin_o.level) else $error("pin missed event");
endmodule
bind amp_interrupt_aggregator amp_irq_checker amp_irq_checker_inst (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .src_i, .irq_pin_o);

// ===== testbench/amp_interrupt_aggregator_tb.sv
`timescale 1ns/1ps
module amp_interrupt_aggregator_tb;
	import amp_irq_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, wire_lvl, irq, ack;
	logic [3:0] sel, lanes;
	logic [7:0] adr, dwr;
	logic [31:0] rdat, dat_o;
	logic [1:0] style;
	logic [5:0] clip;
	logic [3:0] pev;
	src_events_type src;
	irq_pin_type pin;
	int bad_count = 0;
	int total_checks = 0;

	amp_interrupt_aggregator amp_interrupt_aggregator_inst (.clk_i, .rst_i,
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i({24'h0, dwr}), .wb_dat_o(dat_o), .wb_ack_o(ack), .src_i(src),
		.channel_clip_bit_i(clip), .pin_event_i(pev), .irq_pin_o(pin));
	amp_irq_host_model amp_irq_host_model_inst (.pin_i(pin), .style_i(style),
		.wire_o(wire_lvl), .irq_o(irq));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic report_and_stop();
		if (bad_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pchk(input logic [1:0] exp);
		chk({30'h0, irq, wire_lvl}, {30'h0, exp});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle; caller stands just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= a;
		dwr <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask
	// pulse held one cycle, like the upstream ramp logic
	task automatic pulse(input int b);
		src[b] <= 1'b1;
		@(posedge clk_i);
		src[b] <= 1'b0;
		@(posedge clk_i);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_basic();
		rd(8'hA0, 8'h00);
		rd(8'hA8, 8'h00);
		rd(8'h00, 8'h00);
		pchk(2'b00);
		bus(1'b1, 8'hA4, 8'hFF);
		rd(8'hA4, 8'hFC);
		// low lane off: the write must be ignored
		lanes = 4'hE;
		bus(1'b1, 8'hA4, 8'h00);
		lanes = 4'hF;
		rd(8'hA4, 8'hFC);
		bus(1'b1, 8'hA8, 8'hFF);
		bus(1'b1, 8'hA4, 8'h00);
		pulse(2);
		pulse(1);
		pulse(0);
		pchk(2'b00);
		rd(8'hA8, 8'h38);
		rd(8'hA8, 8'h00);
	endtask
	task automatic t_lock();
		src.conv_locked <= 1'b0;
		wt(2);
		src.conv_locked <= 1'b1;
		wt(2);
		rd(8'hA8, 8'h40);
		src.port_error <= 1'b1;
		wt(2);
		rd(8'hA8, 8'h80);
		rd(8'hA8, 8'h00);
		src.port_error <= 1'b0;
		wt(2);
		src.port_error <= 1'b1;
		wt(2);
		rd(8'hA8, 8'h80);
		src.port_error <= 1'b0;
		wt(2);
		rd(8'hA8, 8'h40);
	endtask
	task automatic t_ovf();
		clip <= 6'h04;
		wt(3);
		rd(8'hA8, 8'h04);
		rd(8'hA8, 8'h04);
		rd(8'hAC, 8'h04);
		rd(8'hAC, 8'h04);
		clip <= 6'h00;
		rd(8'hAC, 8'h04);
		rd(8'hA8, 8'h00);
		bus(1'b1, 8'hA0, 8'h01);
		clip <= 6'h01;
		wt(3);
		rd(8'hA8, 8'h04);
		rd(8'hAC, 8'h01);
		rd(8'hA8, 8'h00);
		clip <= 6'h00;
	endtask
	task automatic t_pin();
		bus(1'b1, 8'hC0, 8'h01);
		pev <= 4'h3;
		wt(8);
		rd(8'hA8, 8'h02);
		pev <= 4'h0;
		wt(8);
		rd(8'hBC, 8'h03);
		rd(8'hA8, 8'h00);
		pev <= 4'h2;
		wt(8);
		rd(8'hA8, 8'h00);
		pev <= 4'h0;
		wt(8);
		rd(8'hBC, 8'h02);
		// pin 0 edge triggered: one set per rise, read clears
		bus(1'b1, 8'hB8, 8'h01);
		rd(8'hB8, 8'h01);
		pev <= 4'h1;
		wt(8);
		rd(8'hA8, 8'h02);
		rd(8'hBC, 8'h01);
		rd(8'hA8, 8'h00);
		pev <= 4'h0;
		wt(8);
		rd(8'hBC, 8'h00);
	endtask
	// reserved style keeps the pin released; mid-run reset clears all
	task automatic t_reset();
		bus(1'b1, 8'hA0, 8'hC0);
		style <= 2'h3;
		wt(2);
		pchk(2'b01);
		pulse(0);
		wt(1);
		pchk(2'b01);
		rd(8'hA8, 8'h08);
		bus(1'b1, 8'hA0, 8'h01);
		style <= 2'h0;
		clip <= 6'h20;
		wt(3);
		clip <= 6'h00;
		rd(8'hA0, 8'h01);
		rd(8'hA8, 8'h04);
		rst_i <= 1'b1;
		wt(2);
		rst_i <= 1'b0;
		wt(1);
		rd(8'hAC, 8'h00);
		rd(8'hA0, 8'h00);
		rd(8'hA4, 8'h00);
		pchk(2'b00);
	endtask
	// every usable style: idle, pending, then cleared by the read
	task automatic t_style();
		bus(1'b1, 8'hA4, 8'h08);
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, 8'hA0, {s[1:0], 6'h00});
			style <= s[1:0];
			wt(2);
			pchk({1'b0, s != 0});
			pulse(0);
			wt(1);
			pchk({1'b1, s == 0});
			rd(8'hA8, 8'h08);
			wt(2);
			pchk({1'b0, s != 0});
		end
	endtask
	// ----------------------------------------
	// main
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, dwr, clip, pev, style} = '0;
		sel = 4'hF;
		lanes = 4'hF;
		src = '0;
		src.conv_locked = 1'b1;
		wt(10);
		rst_i <= 1'b0;
		wt(1);
		t_basic();
		t_lock();
		t_ovf();
		t_pin();
		t_style();
		t_reset();
		report_and_stop();
	end
	// a hung handshake ends here
	initial begin
		#1000000;
		bad_count++;
		report_and_stop();
	end
endmodule

// ===== testbench/amp_irq_host_model.sv
`timescale 1ns/1ps
module amp_irq_host_model (
	input wire amp_irq_pkg::irq_pin_type pin_i, // pin drive
	input wire logic [1:0] style_i,             // style chosen
	output logic wire_o,                        // board line
	output logic irq_o                          // host sees request
);
	import amp_irq_pkg::*;
	// board pull-up: a released line reads high, never stale
	assign wire_o = pin_i.oe_n ? 1'b1 : pin_i.level;
	// host decodes the line by the style it programmed
	assign irq_o = (style_i == STYLE_ACTIVE_HIGH) ? wire_o : !wire_o;
endmodule
